// >>> common/pkg_idle_pkg.sv
// Purpose: Types for the package idle state resolver
// Assumes: Constants come from pkg_idle_regs.svh
// Notes: Idle depth is a 4-bit code
package pkg_idle_pkg;
  typedef logic [3:0] cstate_t;
  typedef struct packed {
    logic c3_ok;
    logic c6_ok;
    logic c7_ok;
    logic stay_shallow;
    logic constraint_block;
  } plat_perm_t;
  typedef struct packed {
    logic llc_valid;
    logic [4:0] llc_ways_on;
    logic core_rail_on;
    logic gfx_rail_on;
    logic display_on;
    logic vr_deepest;
    logic io_low_power;
    logic dram_save;
    logic save_sram_gated;
  } pwr_ctl_t;
endpackage

// >>> common/pkg_idle_regs.svh
// Purpose: Constants for the package idle state resolver
// Assumes: 25 MHz core_clk
// Notes: State codes are numeric idle depths
`ifndef PKG_IDLE_REGS_SVH
`define PKG_IDLE_REGS_SVH
`define N_CORES 4
`define N_THREADS 2
`define CST_C0 4'h0
`define CST_C1 4'h1
`define CST_C2 4'h2
`define CST_C3 4'h3
`define CST_C6 4'h6
`define CST_C7 4'h7
`define CST_C8 4'h8
`define CST_C9 4'h9
`define CST_C10 4'ha
`define LLC_WAYS 16
`define LLC_WAY_STEP 5'h04
`define REEXP_TIME_US 100
`define CLK_MHZ 25
`define REEXP_CYCLES (`REEXP_TIME_US * `CLK_MHZ)
`endif

// >>> rtl/package_idle_state_resolver.sv
// Purpose: Resolve package idle state from core, graphics and platform inputs
// Assumes: Platform inputs are synchronous to core_clk
// Notes: One clock domain, no software registers
`timescale 1ns/100ps
`include "pkg_idle_regs.svh"
module package_idle_state_resolver
  import pkg_idle_pkg::*;
#(
  parameter int unsigned REEXP_CYCLES = `REEXP_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Per-thread idle requests, core-major order
  input wire logic [`N_CORES*`N_THREADS*4-1:0] thread_req,
  // Graphics in graphics_power_down_state
  input wire logic graphics_power_down_state,
  // Platform permission and constraints
  input wire plat_perm_t plat_perm,
  // Wake events
  input wire logic mem_access,
  input wire logic mem_outstanding,
  input wire logic break_valid,
  input wire logic [1:0] break_core,
  input wire logic break_masked,
  // Save policy and integrity, flush and depth hints
  input wire logic dram_state_save_mode,
  input wire logic save_corrupt,
  input wire logic flush_all_hint,
  input wire logic heur_deeper,
  // Resolved outputs
  output cstate_t pkg_state,
  output logic [`N_CORES*4-1:0] core_state,
  output logic [`N_CORES-1:0] break_fwd,
  output logic [`N_CORES-1:0] core_wake,
  output pwr_ctl_t pwr_ctl,
  output logic machine_check
);

  // ----------------------------------------------------------------
  // Core and package request resolution
  // ----------------------------------------------------------------
  cstate_t core_res [`N_CORES];
  cstate_t pkg_req;
  logic any_active;
  logic any_c3;
  logic any_c6;

  // Each core takes the shallowest request of its threads
  always_comb begin
    for (int c = 0; c < `N_CORES; c++) begin
      core_res[c] = thread_req[(c*`N_THREADS)*4 +: 4];
      for (int t = 1; t < `N_THREADS; t++) begin
        if (thread_req[(c*`N_THREADS+t)*4 +: 4] < core_res[c]) begin
          core_res[c] = thread_req[(c*`N_THREADS+t)*4 +: 4];
        end
      end
    end
  end

  // Package request is the shallowest core
  always_comb begin
    pkg_req = core_res[0];
    any_active = 1'b0;
    any_c3 = 1'b0;
    any_c6 = 1'b0;
    for (int c = 0; c < `N_CORES; c++) begin
      if (core_res[c] < pkg_req) begin
        pkg_req = core_res[c];
      end
      if (core_res[c] <= `CST_C1) begin
        any_active = 1'b1;
      end
      if (core_res[c] == `CST_C3) begin
        any_c3 = 1'b1;
      end
      if (core_res[c] == `CST_C6) begin
        any_c6 = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Target state selection
  // ----------------------------------------------------------------
  cstate_t target;
  cstate_t pkg_q;
  cstate_t prev_q;
  logic mem_wake_q;
  logic brk_hold_q;

  // Permission caps depth; cores may stay deeper than package
  always_comb begin
    target = `CST_C0;
    if (any_active || !plat_perm.c3_ok) begin
      target = `CST_C0;
    end else if (plat_perm.constraint_block && graphics_power_down_state) begin
      target = `CST_C2;
    end else if (pkg_req >= `CST_C7 && plat_perm.c7_ok) begin
      target = pkg_req;
    end else if (pkg_req >= `CST_C6 && plat_perm.c6_ok && (any_c6 || heur_deeper)) begin
      target = `CST_C6;
    end else if (pkg_req >= `CST_C3 && (any_c3 || pkg_req >= `CST_C6)) begin
      target = `CST_C3;
    end
    if (target == `CST_C3 && heur_deeper && plat_perm.c6_ok) begin
      target = `CST_C6;
    end
  end

  // ----------------------------------------------------------------
  // Package state register
  // ----------------------------------------------------------------
  // Follows target next edge except on an unmasked break (C0) or memory access (C2), or while a memory wake or masked break hold holds the state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pkg_q <= `CST_C0;
    end else if (break_valid && !break_masked) begin
      pkg_q <= `CST_C0;
    end else if (mem_access && pkg_q >= `CST_C3 && graphics_power_down_state) begin
      pkg_q <= `CST_C2;
    end else if (mem_wake_q && plat_perm.stay_shallow) begin
      pkg_q <= (target == `CST_C0) ? `CST_C0 : pkg_q;
    end else if (mem_wake_q && !mem_outstanding) begin
      pkg_q <= (target == `CST_C0) ? `CST_C0 : prev_q;
    end else if (brk_hold_q) begin
      pkg_q <= (target == `CST_C0) ? `CST_C0 : prev_q;
    end else if (!mem_wake_q) begin
      pkg_q <= target;
    end
  end

  // Remember the state held before a wake
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_q <= `CST_C0;
    end else if ((mem_access || break_valid) && !mem_wake_q && !brk_hold_q) begin
      prev_q <= pkg_q;
    end
  end

  // Memory wake tracking; cleared when requests drain unless the platform holds shallow
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_wake_q <= 1'b0;
    end else if (mem_access && pkg_q >= `CST_C3 && graphics_power_down_state) begin
      mem_wake_q <= 1'b1;
    end else if (break_valid || target == `CST_C0 || (!mem_outstanding && !plat_perm.stay_shallow)) begin
      mem_wake_q <= 1'b0;
    end
  end

  // Masked break holds one cycle then re-enters prior state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      brk_hold_q <= 1'b0;
    end else begin
      brk_hold_q <= break_valid && break_masked && pkg_q != `CST_C0;
    end
  end

  // ----------------------------------------------------------------
  // Break forwarding and core view
  // ----------------------------------------------------------------
  // One-cycle wake and message to the target core
  always_ff @(posedge core_clk) begin
    if (srst) begin
      break_fwd <= '0;
      core_wake <= '0;
    end else begin
      break_fwd <= '0;
      core_wake <= '0;
      if (break_valid) begin
        break_fwd[break_core] <= 1'b1;
        core_wake[break_core] <= 1'b1;
      end
    end
  end

  // Resolved core states; an unmasked break forces the core active
  always_ff @(posedge core_clk) begin
    if (srst) begin
      core_state <= '0;
    end else begin
      for (int c = 0; c < `N_CORES; c++) begin
        if (break_valid && !break_masked && break_core == c[1:0]) begin
          core_state[c*4 +: 4] <= `CST_C0;
        end else begin
          core_state[c*4 +: 4] <= core_res[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Last-level cache sizing
  // ----------------------------------------------------------------
  logic [4:0] ways_q;
  logic [$clog2(REEXP_CYCLES+1)-1:0] out_cnt_q;
  logic flushed_q;

  // Flush by ways or all at once; re-expand after time in C0
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ways_q <= 5'(`LLC_WAYS);
      flushed_q <= 1'b0;
      out_cnt_q <= '0;
    end else if (pkg_q >= `CST_C8) begin
      ways_q <= 5'h00;
      flushed_q <= 1'b1;
      out_cnt_q <= '0;
    end else if (pkg_q == `CST_C7) begin
      out_cnt_q <= '0;
      if (flush_all_hint || ways_q <= `LLC_WAY_STEP) begin
        ways_q <= 5'h00;
        flushed_q <= 1'b1;
      end else begin
        ways_q <= ways_q - `LLC_WAY_STEP;
      end
    end else if (pkg_q == `CST_C0 && flushed_q) begin
      if (ways_q == 5'h00) begin
        ways_q <= `LLC_WAY_STEP;
      end else if (out_cnt_q >= ($clog2(REEXP_CYCLES+1))'(REEXP_CYCLES - 1)) begin
        ways_q <= 5'(`LLC_WAYS);
        flushed_q <= 1'b0;
      end else begin
        out_cnt_q <= out_cnt_q + 1'b1;
        if (ways_q < 5'(`LLC_WAYS) - `LLC_WAY_STEP) begin
          ways_q <= ways_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power controls and machine check
  // ----------------------------------------------------------------
  // Rail and save controls follow the package state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_ctl <= '{llc_valid: 1'b1, llc_ways_on: 5'(`LLC_WAYS), core_rail_on: 1'b1,
                   gfx_rail_on: 1'b1, display_on: 1'b1, vr_deepest: 1'b0,
                   io_low_power: 1'b0, dram_save: 1'b0, save_sram_gated: 1'b0};
    end else begin
      pwr_ctl.llc_valid <= pkg_q <= `CST_C3 || ways_q != 5'h00;
      pwr_ctl.llc_ways_on <= ways_q;
      pwr_ctl.core_rail_on <= pkg_q < `CST_C6;
      pwr_ctl.gfx_rail_on <= pkg_q < `CST_C8;
      pwr_ctl.display_on <= 1'b1;
      pwr_ctl.vr_deepest <= pkg_q == `CST_C10;
      pwr_ctl.io_low_power <= pkg_q == `CST_C10;
      pwr_ctl.dram_save <= dram_state_save_mode && pkg_q >= `CST_C6;
      pwr_ctl.save_sram_gated <= dram_state_save_mode && pkg_q >= `CST_C6;
    end
  end

  // Sticky until reset; corruption only matters with DRAM save
  always_ff @(posedge core_clk) begin
    if (srst) begin
      machine_check <= 1'b0;
    end else if (save_corrupt && dram_state_save_mode) begin
      machine_check <= 1'b1;
    end
  end

  assign pkg_state = pkg_q;

endmodule // package_idle_state_resolver

// >>> verification/idle_resolver_sva.sv
// Purpose: Port-level checks on the package idle state resolver
// Assumes: One clock, synchronous active-high reset
// Notes: Target checks skip cycles near wake traffic
`timescale 1ns/100ps
`include "pkg_idle_regs.svh"
module idle_resolver_sva
  import pkg_idle_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Inputs watched
  input wire logic [31:0] thread_req,
  input wire logic graphics_power_down_state,
  input wire plat_perm_t plat_perm,
  input wire logic mem_access,
  input wire logic mem_outstanding,
  input wire logic break_valid,
  input wire logic [1:0] break_core,
  input wire logic break_masked,
  input wire logic dram_state_save_mode,
  input wire logic save_corrupt,
  // Outputs watched
  input wire cstate_t pkg_state,
  input wire logic [15:0] core_state,
  input wire logic [3:0] break_fwd,
  input wire logic [3:0] core_wake,
  input wire pwr_ctl_t pwr_ctl,
  input wire logic machine_check
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Wake traffic this or last cycle may legally hold an older state
  logic calm_q;
  wire calm = !mem_access && !mem_outstanding && !break_valid;
  wire [3:0] cmin = thread_req[3:0] < thread_req[7:4] ? thread_req[3:0] : thread_req[7:4];
  always_ff @(posedge core_clk) begin
    calm_q <= !srst && calm;
  end
  // Way count lags the state by two cycles, so hold three
  sequence s_deep;
    pkg_state >= `CST_C8 [*3];
  endsequence
  sequence s_masked;
    break_valid && break_masked && pkg_state != `CST_C0 ##1 calm && $stable(thread_req) && $stable(plat_perm);
  endsequence
  property p_break_pulse;
    break_valid |=> break_fwd == 4'h1 << $past(break_core) && core_wake == break_fwd;
  endproperty
  a_break_pulse: assert property (p_break_pulse) else $error("break pulse wrong");
  property p_unmasked;
    break_valid && !break_masked |=> pkg_state == `CST_C0 && core_state[$past(break_core)*4 +: 4] == `CST_C0;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("unmasked break not active");
  property p_masked;
    s_masked |=> pkg_state == $past(pkg_state, 2);
  endproperty
  a_masked: assert property (p_masked) else $error("masked break no return");
  property p_c0_hold;
    calm && calm_q && (!plat_perm.c3_ok || thread_req[3:0] <= `CST_C1 || thread_req[7:4] <= `CST_C1)
      |=> pkg_state == `CST_C0;
  endproperty
  a_c0_hold: assert property (p_c0_hold) else $error("package left active");
  property p_core_min;
    calm && calm_q |=> core_state[3:0] == $past(cmin);
  endproperty
  a_core_min: assert property (p_core_min) else $error("core state not lowest");
  property p_mem_c2;
    mem_access && !break_valid && plat_perm.c3_ok && graphics_power_down_state && pkg_state >= `CST_C3
      && $stable(thread_req) |=> pkg_state == `CST_C2;
  endproperty
  a_mem_c2: assert property (p_mem_c2) else $error("memory wake not C2");
  property p_c8;
    s_deep |-> !pwr_ctl.core_rail_on && !pwr_ctl.gfx_rail_on && pwr_ctl.display_on && pwr_ctl.llc_ways_on == 5'h00;
  endproperty
  a_c8: assert property (p_c8) else $error("deep rails wrong");
  property p_c10;
    pkg_state == `CST_C10 [*2] |-> pwr_ctl.vr_deepest && pwr_ctl.io_low_power;
  endproperty
  a_c10: assert property (p_c10) else $error("C10 supplies wrong");
  property p_mc;
    $rose(machine_check) |-> $past(save_corrupt) && $past(dram_state_save_mode);
  endproperty
  a_mc: assert property (p_mc) else $error("machine check without cause");
endmodule // idle_resolver_sva
bind package_idle_state_resolver idle_resolver_sva i_sva (.core_clk, .srst, .thread_req,
  .graphics_power_down_state, .plat_perm, .mem_access, .mem_outstanding, .break_valid, .break_core,
  .break_masked, .dram_state_save_mode, .save_corrupt, .pkg_state, .core_state, .break_fwd, .core_wake,
  .pwr_ctl, .machine_check);

// >>> verification/platform_perm_model.sv
// Purpose: Platform controller granting package idle permission
// Assumes: Bench sets the wanted grant
// Notes: Slow mode adds one cycle of grant latency
`timescale 1ns/100ps
module platform_perm_model
  import pkg_idle_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Commanded grant and pace
  input wire plat_perm_t want,
  input wire logic slow,
  // Grant to the resolver
  output plat_perm_t plat_perm
);
  plat_perm_t delay_q;
  // Every field, withholding and shallow holds included, takes the same path; slow delays all
  always_ff @(posedge core_clk) begin
    delay_q <= srst ? 5'h00 : want;
    plat_perm <= srst ? 5'h00 : (slow ? delay_q : want);
  end
endmodule // platform_perm_model

// >>> verification/test_package_idle_state_resolver.sv
// Purpose: Self-checking bench for the idle resolver
// Assumes: Graphics stays powered down throughout
// Notes: Seeded random depths plus wake corner cases
`timescale 1ns/100ps
`include "pkg_idle_regs.svh"
module test_package_idle_state_resolver
  import pkg_idle_pkg::*;
;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic [31:0] thread_req = 32'h0000_0000;
  logic graphics_power_down_state = 1'h1;
  logic mem_access = 1'h0, mem_outstanding = 1'h0, break_valid = 1'h0, break_masked = 1'h0;
  logic dram_state_save_mode = 1'h0, save_corrupt = 1'h0, flush_all_hint = 1'h0, heur_deeper = 1'h0;
  logic slow = 1'h0;
  logic [1:0] break_core = 2'h0;
  plat_perm_t want = 5'h00;
  plat_perm_t plat_perm;
  cstate_t pkg_state;
  logic [15:0] core_state;
  logic [3:0] break_fwd, core_wake;
  pwr_ctl_t pwr_ctl;
  logic machine_check;
  int err_total = 0;
  int check_count = 0;
  cstate_t codes [6] = '{4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
  package_idle_state_resolver #(.REEXP_CYCLES(8)) i_dut (.core_clk, .srst, .thread_req,
    .graphics_power_down_state, .plat_perm, .mem_access, .mem_outstanding, .break_valid, .break_core,
    .break_masked, .dram_state_save_mode, .save_corrupt, .flush_all_hint, .heur_deeper, .pkg_state,
    .core_state, .break_fwd, .core_wake, .pwr_ctl, .machine_check);
  platform_perm_model i_plat (.core_clk, .srst, .want, .slow, .plat_perm);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Expected package state; graphics is always down here
  function automatic cstate_t exp_pkg(input logic [31:0] tr, input plat_perm_t p, input logic hd);
    cstate_t m;
    m = 4'hf;
    for (int i = 0; i < 8; i++) if (tr[i*4 +: 4] < m) m = tr[i*4 +: 4];
    if (m <= 4'h1 || !p.c3_ok) return 4'h0;
    if (p.constraint_block) return 4'h2;
    if (m >= 4'h7 && p.c7_ok) return m;
    if (p.c6_ok && (m == 4'h6 || hd)) return 4'h6;
    return 4'h3;
  endfunction
  // Grant path may take two cycles, state and controls two more
  task automatic apply(input logic [31:0] tr, input plat_perm_t p);
    thread_req = tr;
    want = p;
    step(5);
    chk(pkg_state, exp_pkg(tr, p, heur_deeper));
  endtask
  initial begin
    logic [31:0] tr;
    tr = $urandom(13402);
    step(6);
    srst = 1'h0;
    // Every software depth on all threads, full grant
    for (int c = 0; c < 11; c++) if (c != 2 && (c < 4 || c > 5)) apply({8{c[3:0]}}, 5'h1c);
    chk({pwr_ctl.llc_valid, pwr_ctl.core_rail_on, pwr_ctl.gfx_rail_on, pwr_ctl.display_on}, 4'h1);
    chk({pwr_ctl.vr_deepest, pwr_ctl.io_low_power}, 2'h3);
    apply(32'h0000_0000, 5'h1c);
    chk(pwr_ctl.llc_ways_on < 5'h10, 1'h1);
    step(20);
    chk(pwr_ctl.llc_ways_on, 5'h10);
    // Random deep requests, grants, heuristic and flush hint
    repeat (40) begin
      for (int i = 0; i < 8; i++) tr[i*4 +: 4] = codes[$urandom_range(5)];
      heur_deeper = $urandom_range(1);
      flush_all_hint = $urandom_range(1);
      slow = $urandom_range(1);
      apply(tr, plat_perm_t'($urandom_range(31)) & 5'h1d);
    end
    // Core break on an all-C6 package, unmasked then masked
    for (int m = 0; m < 2; m++) begin
      apply({8{4'h6}}, 5'h1c);
      break_core = $urandom_range(3);
      break_masked = m[0];
      break_valid = 1'h1;
      step(1);
      break_valid = 1'h0;
      chk(break_fwd, 4'h1 << break_core);
      chk(core_wake, 4'h1 << break_core);
      if (m == 0) chk(pkg_state, 4'h0);
      if (m == 0) chk(core_state[break_core*4 +: 4], 4'h0);
      if (m == 1) chk(pkg_state, 4'h6);
      step(1);
      if (m == 1) chk(pkg_state, 4'h6);
    end
    // Memory wake from C6, second pass with the platform holding shallow
    for (int s = 0; s < 2; s++) begin
      apply({8{4'h6}}, s ? 5'h1e : 5'h1c);
      mem_access = 1'h1;
      mem_outstanding = 1'h1;
      step(1);
      mem_access = 1'h0;
      step(1);
      chk(pkg_state, 4'h2);
      mem_outstanding = 1'h0;
      step(3);
      chk(pkg_state, s ? 4'h2 : 4'h6);
    end
    // State saved to memory, then found corrupt
    dram_state_save_mode = 1'h1;
    apply({8{4'h8}}, 5'h1c);
    chk({pwr_ctl.dram_save, pwr_ctl.save_sram_gated}, 2'h3);
    save_corrupt = 1'h1;
    step(2);
    save_corrupt = 1'h0;
    step(2);
    chk(machine_check, 1'h1);
    end_sim;
  end
  // About 315 cycles expected; over six times that means a hang
  initial begin
    #(40 * 2000);
    err_total++;
    end_sim;
  end
endmodule // test_package_idle_state_resolver
